// File: pkg/core_ctrl_pkg.sv
// shared constants and types for the status, interrupt and reset control core
package core_ctrl_pkg;
    // ==========================================
    // register map (apb byte addresses)
    localparam logic [7:0] ADDR_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_PEND = 8'h04;
    localparam logic [7:0] ADDR_ENABLE = 8'h08;
    localparam logic [7:0] ADDR_INTSTAT = 8'h0c;
    localparam logic [7:0] ADDR_RSTCAUSE = 8'h10;
    // ==========================================
    // flag register fields
    localparam int BIT_CARRY = 0;
    localparam int BIT_HALF = 1;
    localparam int BIT_ZERO = 2;
    localparam int BIT_PD = 3;
    localparam int BIT_WDX = 4;
    localparam int BIT_BANK = 5;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] FLAGS_SW_MASK = 8'he7;
    localparam logic [7:0] FLAGS_ALU_MASK = 8'h07;
    // ==========================================
    // config fuse word fields
    localparam int CFG_WIDTH = 14;
    localparam int CFG_PIN_RST_EN = 7;
    localparam int CFG_WDT_RST_EN = 6;
    localparam int CFG_BOR_LO = 10;
    localparam int CFG_BOR_HI = 11;
    // ==========================================
    // program vectors and misc
    localparam int PC_WIDTH = 12;
    localparam logic [11:0] RESET_VECTOR = 12'h000;
    localparam logic [11:0] INT_VECTOR = 12'h001;
    localparam logic [1:0] BOR_HIGH = 2'h0;
    localparam logic [1:0] BOR_MID = 2'h1;
    localparam int RST_STRETCH_CYCLES = 4;

    typedef enum logic [1:0] {ALU_NONE, ALU_ADD, ALU_SUB, ALU_LOGIC} alu_op_t;
    typedef enum {IRQ_IDLE, IRQ_INJECT, IRQ_BLOCKED, IRQ_RELEASE} irq_state_t;
endpackage

// File: pkg/flag_update_if.sv
// flag update bundle between the core control top and the flag unit
interface flag_update_if;
    import core_ctrl_pkg::*;
    logic [7:0] flags;
    logic [7:0] swData;
    logic swWrite;
    logic aluValid;
    logic aluToFlags;
    alu_op_t aluOp;
    logic [7:0] aluA;
    logic [7:0] aluB;
    logic [7:0] aluResult;
    logic wdtTimeout;
    logic wdtClear;
    logic sleepInstr;
    logic causeClear;
    modport owner(output swData, swWrite, aluValid, aluToFlags, aluOp, aluA, aluB, aluResult,
        wdtTimeout, wdtClear, sleepInstr, causeClear, input flags);
    modport unit(input swData, swWrite, aluValid, aluToFlags, aluOp, aluA, aluB, aluResult,
        wdtTimeout, wdtClear, sleepInstr, causeClear, output flags);
endinterface

// File: core/alu_flag_unit.sv
// alu status flags and reset-cause flags
module alu_flag_unit
    import core_ctrl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sysReset,
    input wire logic clkEn,
    flag_update_if.unit fu
);
    import core_ctrl_pkg::*;

    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic [8:0] nibSum;
    logic [8:0] full;

    function automatic logic [8:0] addsub(input logic [7:0] a, input logic [7:0] b, input logic sub);
        addsub = sub ? ({1'b0, a} + {1'b0, ~b} + 9'h001) : ({1'b0, a} + {1'b0, b});
    endfunction

    assign fu.flags = flags_reg;

    always_comb begin
        // nibbles in the top half so that bit 8 is the nibble carry for add and sub
        nibSum = addsub({fu.aluA[3:0], 4'h0}, {fu.aluB[3:0], 4'h0}, fu.aluOp == ALU_SUB);
        full = addsub(fu.aluA, fu.aluB, fu.aluOp == ALU_SUB);
        flags_next = flags_reg;
        // software writes: alu bits blocked when the alu also targets flags
        if (fu.swWrite) begin
            if (fu.aluValid && fu.aluToFlags && fu.aluOp != ALU_NONE) begin
                flags_next = (flags_reg & ~(FLAGS_SW_MASK & ~FLAGS_ALU_MASK))
                    | (fu.swData & FLAGS_SW_MASK & ~FLAGS_ALU_MASK);
            end else begin
                flags_next = (flags_reg & ~FLAGS_SW_MASK) | (fu.swData & FLAGS_SW_MASK);
            end
        end
        if (fu.aluValid && fu.aluOp != ALU_NONE) begin
            flags_next[BIT_ZERO] = (fu.aluResult == 8'h00);
            if (fu.aluOp != ALU_LOGIC) begin
                // sub uses a+~b+1, so carry out means no borrow
                flags_next[BIT_HALF] = nibSum[8];
                flags_next[BIT_CARRY] = full[8];
            end
        end
        // reset-cause flags, read-only to software
        if (fu.sleepInstr) begin
            flags_next[BIT_PD] = 1'b1;
            flags_next[BIT_WDX] = 1'b0;
        end
        if (fu.wdtClear) begin
            flags_next[BIT_PD] = 1'b0;
            flags_next[BIT_WDX] = 1'b0;
        end
        if (fu.wdtTimeout) begin
            flags_next[BIT_WDX] = 1'b1;
        end
    end

    // ==========================================
    // state
    always_ff @(posedge ref_clk) begin
        if (fu.causeClear) begin
            flags_reg <= FLAGS_RESET;
        end else if (sysReset) begin
            // pin/watchdog reset keeps cause flags
            flags_reg <= (FLAGS_RESET & FLAGS_SW_MASK) | (flags_reg & ~FLAGS_SW_MASK);
        end else if (clkEn) begin
            flags_reg <= flags_next;
        end
    end
endmodule

// File: core/irq_unit.sv
// eight-source single-vector interrupt unit
module irq_unit
    import core_ctrl_pkg::*;
#(
    parameter int NUM_SRC = 8
) (
    input wire logic ref_clk,
    input wire logic sysReset,
    input wire logic clkEn,
    input wire logic [NUM_SRC-1:0] srcEvent,
    input wire logic [NUM_SRC-1:0] enableBits,
    input wire logic [NUM_SRC-1:0] pendClear,
    input wire logic instrEnd,
    input wire logic retiDone,
    output logic [NUM_SRC-1:0] pending,
    output logic injectCall,
    output logic nestBlock
);
    import core_ctrl_pkg::*;

    irq_state_t state_reg;
    logic [NUM_SRC-1:0] pend_reg;
    logic request;

    if (NUM_SRC < 1 || NUM_SRC > 8) begin
        $error("irq_unit: NUM_SRC must be 1..8");
    end

    assign pending = pend_reg;
    // level request, no priority among sources
    assign request = |(pend_reg & enableBits);
    assign injectCall = (state_reg == IRQ_INJECT);
    assign nestBlock = (state_reg != IRQ_IDLE);

    // set wins over clear
    always_ff @(posedge ref_clk) begin
        if (sysReset) begin
            pend_reg <= '0;
        end else if (clkEn) begin
            pend_reg <= (pend_reg & ~pendClear) | srcEvent;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sysReset) begin
            state_reg <= IRQ_IDLE;
        end else if (clkEn) begin
            unique case (state_reg)
                IRQ_IDLE: if (request && instrEnd) begin
                    state_reg <= IRQ_INJECT;
                end
                IRQ_INJECT: state_reg <= IRQ_BLOCKED;
                IRQ_BLOCKED: if (retiDone) begin
                    state_reg <= IRQ_RELEASE;
                end
                // block lifts only after the next instruction completes
                IRQ_RELEASE: if (instrEnd) begin
                    state_reg <= IRQ_IDLE;
                end
            endcase
        end
    end
endmodule

// File: core/status_interrupt_reset_ctrl.sv
// top: apb registers, reset combining, flags and interrupt control
// ==========================================
//
// Implementation choices: the register offsets and register access over APB.
module status_interrupt_reset_ctrl
    import core_ctrl_pkg::*;
#(
    parameter int NUM_SRC = 8
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // reset sources
    input wire logic [core_ctrl_pkg::CFG_WIDTH-1:0] config_fuse_word,
    input wire logic powerOnReset,
    input wire logic [2:0] brownoutBelow,
    input wire logic ext_reset_pin,
    input wire logic wdtTimeout,
    // cpu pipeline
    input wire logic instrEnd,
    input wire logic retiDone,
    input wire logic wdtClearInstr,
    input wire logic sleepInstr,
    input wire logic aluValid,
    input wire logic aluToFlags,
    input wire core_ctrl_pkg::alu_op_t aluOp,
    input wire logic [7:0] aluA,
    input wire logic [7:0] aluB,
    input wire logic [7:0] aluResult,
    input wire logic [7:0] cpuFlagData,
    input wire logic cpuFlagWrite,
    input wire logic [NUM_SRC-1:0] srcEvent,
    output logic sysReset,
    output logic [7:0] flagsOut,
    output logic injectCall,
    output logic pushReturn,
    output logic [core_ctrl_pkg::PC_WIDTH-1:0] vectorAddr,
    output logic nestBlock,
    output logic extPinIn
);
    import core_ctrl_pkg::*;

    if (NUM_SRC < 1 || NUM_SRC > 8) begin
        $error("NUM_SRC must be 1..8");
    end

    // ==========================================
    // pin and reset source synchronisers
    logic [1:0] pinSync_reg;
    logic [1:0] wdtSync_reg;
    logic [1:0] porSync_reg;
    logic [2:0] borSync1_reg;
    logic [2:0] borSync2_reg;
    logic [2:0] rstCause_reg;
    logic [$clog2(RST_STRETCH_CYCLES+1)-1:0] rstCnt_reg;
    logic borActive;
    logic pinRst;
    logic wdtRst;
    logic anyRst;
    logic causeClear;

    always_ff @(posedge ref_clk) begin
        pinSync_reg <= {pinSync_reg[0], ext_reset_pin};
        wdtSync_reg <= {wdtSync_reg[0], wdtTimeout};
        porSync_reg <= {porSync_reg[0], powerOnReset | ~reset_n};
        borSync1_reg <= brownoutBelow;
        borSync2_reg <= borSync1_reg;
    end

    // selected level from fuse bits 11:10
    always_comb begin
        unique case (config_fuse_word[CFG_BOR_HI:CFG_BOR_LO])
            BOR_HIGH: borActive = borSync2_reg[2];
            BOR_MID: borActive = borSync2_reg[1];
            default: borActive = borSync2_reg[0];
        endcase
    end

    // pin is reset only when enabled pin active low
    assign pinRst = config_fuse_word[CFG_PIN_RST_EN] & ~pinSync_reg[1];
    assign wdtRst = config_fuse_word[CFG_WDT_RST_EN] & wdtSync_reg[1];
    assign causeClear = porSync_reg[1] | borActive;
    assign anyRst = causeClear | pinRst | wdtRst;

    // stretch reset; brownout holds it for as long as it lasts
    always_ff @(posedge ref_clk) begin
        if (anyRst) begin
            rstCnt_reg <= RST_STRETCH_CYCLES[$bits(rstCnt_reg)-1:0];
        end else if (rstCnt_reg != '0) begin
            rstCnt_reg <= rstCnt_reg - 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        sysReset <= anyRst | (rstCnt_reg != '0);
    end

    always_ff @(posedge ref_clk) begin
        if (porSync_reg[1]) begin
            rstCause_reg <= 3'h0;
        end else if (anyRst) begin
            rstCause_reg <= rstCause_reg | {wdtRst, pinRst, borActive};
        end
    end

    // plain input when not used as reset
    always_ff @(posedge ref_clk) begin
        if (sysReset) begin
            extPinIn <= 1'b0;
        end else begin
            extPinIn <= config_fuse_word[CFG_PIN_RST_EN] ? 1'b0 : pinSync_reg[1];
        end
    end

    // ==========================================
    // apb slave
    logic apbWrite;
    logic apbRead;
    logic [NUM_SRC-1:0] enable_reg;
    logic [NUM_SRC-1:0] pendClear;
    logic [NUM_SRC-1:0] pending;
    logic [7:0] flags;
    logic flagSwWrite;
    logic [7:0] flagSwData;
    logic injectNow;
    logic nestNow;
    logic addrOk;

    assign apbWrite = psel & penable & pwrite & ~pready;
    assign apbRead = psel & penable & ~pwrite & ~pready;
    assign addrOk = paddr == ADDR_FLAGS || paddr == ADDR_PEND || paddr == ADDR_ENABLE
        || paddr == ADDR_INTSTAT || paddr == ADDR_RSTCAUSE;

    // one wait state: pready pulses in the second access cycle
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (clkEn) begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~addrOk;
            if (apbRead) begin
                unique case (paddr)
                    ADDR_FLAGS: prdata <= {24'h000000, flags};
                    ADDR_PEND: prdata <= {{(32 - NUM_SRC){1'b0}}, pending};
                    ADDR_ENABLE: prdata <= {{(32 - NUM_SRC){1'b0}}, enable_reg};
                    ADDR_INTSTAT: prdata <= {30'h0, injectNow, nestNow};
                    ADDR_RSTCAUSE: prdata <= {29'h0, rstCause_reg};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // enables steer the interrupt request
    always_ff @(posedge ref_clk) begin
        if (sysReset) begin
            enable_reg <= '0;
        end else if (clkEn && apbWrite && paddr == ADDR_ENABLE) begin
            enable_reg <= pwdata[NUM_SRC-1:0];
        end
    end

    // write one to clear pending; firmware duty
    assign pendClear = (apbWrite && clkEn && paddr == ADDR_PEND) ? pwdata[NUM_SRC-1:0] : '0;
    assign flagSwWrite = cpuFlagWrite | (apbWrite && paddr == ADDR_FLAGS);
    assign flagSwData = cpuFlagWrite ? cpuFlagData : pwdata[7:0];

    // ==========================================
    // flag unit
    flag_update_if fu();
    assign fu.swData = flagSwData;
    assign fu.swWrite = flagSwWrite;
    assign fu.aluValid = aluValid;
    assign fu.aluToFlags = aluToFlags;
    assign fu.aluOp = aluOp;
    assign fu.aluA = aluA;
    assign fu.aluB = aluB;
    assign fu.aluResult = aluResult;
    assign fu.wdtTimeout = wdtSync_reg[1];
    assign fu.wdtClear = wdtClearInstr;
    assign fu.sleepInstr = sleepInstr;
    assign fu.causeClear = causeClear;
    assign flags = fu.flags;

    alu_flag_unit u_flags (
        .ref_clk(ref_clk),
        .sysReset(sysReset),
        .clkEn(clkEn),
        .fu(fu)
    );

    // ==========================================
    // interrupt unit
    irq_unit #(.NUM_SRC(NUM_SRC)) u_irq (
        .ref_clk(ref_clk),
        .sysReset(sysReset),
        .clkEn(clkEn),
        .srcEvent(srcEvent),
        .enableBits(enable_reg),
        .pendClear(pendClear),
        .instrEnd(instrEnd),
        .retiDone(retiDone),
        .pending(pending),
        .injectCall(injectNow),
        .nestBlock(nestNow)
    );

    // registered cpu-facing outputs
    always_ff @(posedge ref_clk) begin
        if (sysReset) begin
            injectCall <= 1'b0;
            pushReturn <= 1'b0;
            vectorAddr <= RESET_VECTOR;
            nestBlock <= 1'b0;
            flagsOut <= FLAGS_RESET;
        end else if (clkEn) begin
            injectCall <= injectNow;
            pushReturn <= injectNow;
            vectorAddr <= injectNow ? INT_VECTOR : RESET_VECTOR;
            nestBlock <= nestNow;
            flagsOut <= flags;
        end
    end
endmodule

// File: verification/status_interrupt_reset_ctrl_checker.sv
// port assertions for the status, interrupt and reset control core
module ctrl_port_checker
    import core_ctrl_pkg::*;
#(
    parameter int NUM_SRC = 8
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic [core_ctrl_pkg::CFG_WIDTH-1:0] config_fuse_word,
    input wire logic powerOnReset,
    input wire logic [2:0] brownoutBelow,
    input wire logic ext_reset_pin,
    input wire logic retiDone,
    input wire logic sysReset,
    input wire logic injectCall,
    input wire logic pushReturn,
    input wire logic [core_ctrl_pkg::PC_WIDTH-1:0] vectorAddr,
    input wire logic nestBlock,
    input wire logic extPinIn
);
    // ==========================================
    // helpers
    logic [1:0] borSel;
    logic borTrip;
    logic retiSeen;
    assign borSel = config_fuse_word[CFG_BOR_HI:CFG_BOR_LO];
    assign borTrip = (borSel == BOR_HIGH) ? brownoutBelow[2] :
        (borSel == BOR_MID) ? brownoutBelow[1] : brownoutBelow[0];
    // return seen since the last accept
    always_ff @(posedge ref_clk) begin
        if (sysReset || injectCall) begin
            retiSeen <= 1'b0;
        end else if (retiDone) begin
            retiSeen <= 1'b1;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    // ==========================================
    // assertions
    AST_VEC_ONE: assert property (injectCall |-> vectorAddr == INT_VECTOR && pushReturn)
        else $error("accept without vector one or return push");
    AST_VEC_ZERO: assert property (!injectCall |-> vectorAddr == RESET_VECTOR && !pushReturn)
        else $error("vector or push outside an accept");
    AST_INJ_ONCE: assert property (injectCall |=> !injectCall && nestBlock)
        else $error("accept not single or nesting block not set");
    AST_NO_NEST: assert property (nestBlock && $past(nestBlock) |-> !injectCall)
        else $error("accept while nesting block set");
    AST_NEST_REL: assert property ($fell(nestBlock) && !sysReset && !$past(sysReset) |-> retiSeen)
        else $error("nesting block cleared without a return");
    AST_POR: assert property (powerOnReset [*4] |-> sysReset)
        else $error("power-on source without system reset");
    AST_BOR: assert property (borTrip [*4] |-> sysReset)
        else $error("selected low supply level without system reset");
    AST_PIN: assert property ((config_fuse_word[CFG_PIN_RST_EN] && !ext_reset_pin) [*4] |-> sysReset)
        else $error("enabled pin reset ignored");
    AST_PIN_IN: assert property (config_fuse_word[CFG_PIN_RST_EN] && $past(config_fuse_word[CFG_PIN_RST_EN])
        |-> !extPinIn)
        else $error("pin input visible while used as reset");
    AST_APB: assert property ($rose(psel && penable) |-> !pready ##1 pready)
        else $error("access phase length wrong");
endmodule

bind status_interrupt_reset_ctrl ctrl_port_checker #(.NUM_SRC(NUM_SRC)) chk (
    .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pready(pready),
    .config_fuse_word(config_fuse_word), .powerOnReset(powerOnReset), .brownoutBelow(brownoutBelow),
    .ext_reset_pin(ext_reset_pin), .retiDone(retiDone), .sysReset(sysReset), .injectCall(injectCall),
    .pushReturn(pushReturn), .vectorAddr(vectorAddr), .nestBlock(nestBlock), .extPinIn(extPinIn)
);

// File: verification/cpu_pipe_model.sv
// cpu pipeline stand-in: instruction ends every gap+1 cycles, returns on request
module cpu_pipe_model (
    input wire logic ref_clk,
    input wire logic sysReset,
    input wire logic [2:0] gap,
    input wire logic retiReq,
    output logic instrEnd,
    output logic retiDone
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt;
    logic retiPend;
    always_ff @(posedge ref_clk) begin
        if (sysReset) begin
            cnt <= 3'h0;
            instrEnd <= 1'b0;
            retiDone <= 1'b0;
            retiPend <= 1'b0;
        end else begin
            instrEnd <= (cnt == gap);
            cnt <= (cnt == gap) ? 3'h0 : cnt + 3'h1;
            // return ends with its own instruction, release needs a later one
            retiDone <= (cnt == gap) && (retiPend || retiReq);
            retiPend <= (retiPend || retiReq) && (cnt != gap);
        end
    end
endmodule

// File: verification/status_interrupt_reset_ctrl_tb_top.sv
// self-checking bench for the status, interrupt and reset control core
module status_interrupt_reset_ctrl_tb_top
    import core_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(g, e) check((g), (e))
    logic ref_clk, reset_n, clkEn, psel, penable, pwrite, pready, pslverr, powerOnReset, ext_reset_pin;
    logic wdtTimeout, retiDone, instrEnd, wdtClearInstr, sleepInstr, aluValid, aluToFlags, cpuFlagWrite;
    logic sysReset, injectCall, pushReturn, nestBlock, extPinIn, retiReq;
    logic [7:0] paddr, aluA, aluB, aluResult, cpuFlagData, srcEvent, flagsOut, expFlags, ra, rb;
    logic [31:0] pwdata, prdata;
    logic [CFG_WIDTH-1:0] cfg;
    logic [2:0] brownoutBelow, gap;
    logic [PC_WIDTH-1:0] vectorAddr;
    logic [33:0] note;
    logic [33:0] notes[$];
    alu_op_t aluOp;
    int fail_count, compares, injCount;
    status_interrupt_reset_ctrl DUT (
        .ref_clk, .reset_n, .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .config_fuse_word(cfg), .powerOnReset, .brownoutBelow, .ext_reset_pin, .wdtTimeout, .instrEnd,
        .retiDone, .wdtClearInstr, .sleepInstr, .aluValid, .aluToFlags, .aluOp, .aluA, .aluB, .aluResult,
        .cpuFlagData, .cpuFlagWrite, .srcEvent, .sysReset, .flagsOut, .injectCall, .pushReturn,
        .vectorAddr, .nestBlock, .extPinIn
    );
    cpu_pipe_model pipe (.ref_clk, .sysReset, .gap, .retiReq, .instrEnd, .retiDone);
    // ==========================================
    // tasks
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
        notes.push_back({!wr, err, d});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        cyc(1);
        penable <= 1'b1;
        cyc(1);
        while (pready !== 1'b1) cyc(1);
        {psel, penable} <= 2'b00;
        cyc(1);
    endtask
    task automatic pulse(input int k, input logic [7:0] v);
        case (k)
            0: sleepInstr <= 1'b1;
            1: wdtClearInstr <= 1'b1;
            2: retiReq <= 1'b1;
            default: srcEvent <= v;
        endcase
        cyc(1);
        {sleepInstr, wdtClearInstr, retiReq, srcEvent} <= '0;
        cyc(2);
    endtask
    task automatic alu(input alu_op_t op, input logic [7:0] a, input logic [7:0] b, input logic dst);
        logic [8:0] s;
        logic [4:0] h;
        s = (op == ALU_SUB) ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
        h = (op == ALU_SUB) ? {1'b0, a[3:0]} - {1'b0, b[3:0]} : {1'b0, a[3:0]} + {1'b0, b[3:0]};
        if (op == ALU_LOGIC) s = {1'b0, a & b};
        aluOp <= op;
        {aluA, aluB, aluResult} <= {a, b, s[7:0]};
        // written alu bits are zero, so a write that wins shows as a mismatch
        {aluValid, aluToFlags, cpuFlagWrite, cpuFlagData} <= {1'b1, dst, dst, 8'he0};
        cyc(1);
        {aluValid, aluToFlags, cpuFlagWrite} <= 3'b000;
        if (dst) expFlags = expFlags | 8'he0;
        expFlags[BIT_ZERO] = (s[7:0] == 8'h00);
        if (op != ALU_LOGIC) expFlags[BIT_CARRY] = s[8] ^ (op == ALU_SUB);
        if (op != ALU_LOGIC) expFlags[BIT_HALF] = h[4] ^ (op == ALU_SUB);
        apb(1'b0, ADDR_FLAGS, {24'h0, expFlags}, 1'b0);
        `CHK(flagsOut, {24'h0, expFlags});
    endtask
    task automatic hit(input int k, input logic exp);
        case (k)
            0: wdtTimeout <= 1'b1;
            1: ext_reset_pin <= 1'b0;
            2: brownoutBelow <= 3'b110;
            3: powerOnReset <= 1'b1;
            default: brownoutBelow <= 3'b100;
        endcase
        cyc(6);
        `CHK(sysReset, exp);
        {wdtTimeout, powerOnReset, brownoutBelow, ext_reset_pin} <= 6'h01;
        cyc(2);
        while (sysReset !== 1'b0) cyc(1);
        cyc(1);
        apb(1'b0, ADDR_FLAGS, {24'h0, expFlags}, 1'b0);
    endtask
    task automatic close_out();
        $display("compares=%0d mismatches=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ==========================================
    // clock, watchdog, monitors
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // whole run is a few hundred cycles
    initial begin
        #200us;
        fail_count++;
        close_out();
    end
    always @(posedge ref_clk) begin
        if (injectCall === 1'b1) injCount++;
        if (psel && penable && pready === 1'b1) begin
            note = notes.pop_front();
            `CHK(pslverr, note[32]);
            if (note[33]) `CHK(prdata, note[31:0]);
        end
    end
    // ==========================================
    // tests
    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata, powerOnReset, brownoutBelow, wdtTimeout} = '0;
        {wdtClearInstr, sleepInstr, aluValid, aluToFlags, aluA, aluB, aluResult, cpuFlagData} = '0;
        {cpuFlagWrite, srcEvent, retiReq, gap, cfg, expFlags} = '0;
        aluOp = ALU_NONE;
        {clkEn, ext_reset_pin} = 2'b11;
        void'($urandom(85657));
        cyc(8);
        reset_n <= 1'b1;
        cyc(2);
        while (sysReset !== 1'b0) cyc(1);
        apb(1'b0, ADDR_FLAGS, 32'h0, 1'b0);
        apb(1'b0, ADDR_ENABLE, 32'h0, 1'b0);
        apb(1'b0, 8'h3c, 32'h0, 1'b1);
        apb(1'b1, 8'h3c, 32'h5, 1'b1);
        apb(1'b1, ADDR_FLAGS, 32'hff, 1'b0);
        expFlags = FLAGS_SW_MASK;
        apb(1'b0, ADDR_FLAGS, {24'h0, expFlags}, 1'b0);
        `CHK(extPinIn, 1'b1);
        $display("test registers done");
        for (int i = 0; i < 9; i++) begin
            ra = 8'($urandom);
            rb = (i == 4) ? ra : 8'($urandom);
            alu(alu_op_t'(i % 3 + 1), ra, rb, 1'b0);
        end
        alu(ALU_ADD, 8'hff, 8'h01, 1'b1);
        $display("test alu flags done");
        pulse(0, 8'h00);
        // sleep sets power-down, the timeout then sets the expired bit
        expFlags[4:3] = 2'b11;
        hit(0, 1'b0);
        pulse(1, 8'h00);
        expFlags[4:3] = 2'b00;
        apb(1'b0, ADDR_FLAGS, {24'h0, expFlags}, 1'b0);
        pulse(0, 8'h00);
        cfg[CFG_WDT_RST_EN] <= 1'b1;
        expFlags = 8'h18;
        hit(0, 1'b1);
        cfg[CFG_PIN_RST_EN] <= 1'b1;
        hit(1, 1'b1);
        cfg[CFG_PIN_RST_EN] <= 1'b0;
        hit(1, 1'b0);
        cfg[CFG_BOR_HI:CFG_BOR_LO] <= BOR_MID;
        hit(4, 1'b0);
        expFlags = 8'h00;
        hit(2, 1'b1);
        apb(1'b0, ADDR_RSTCAUSE, 32'h7, 1'b0);
        pulse(0, 8'h00);
        hit(3, 1'b1);
        apb(1'b0, ADDR_RSTCAUSE, 32'h0, 1'b0);
        $display("test resets done");
        gap <= 3'h2;
        injCount = 0;
        pulse(3, 8'h08);
        apb(1'b0, ADDR_PEND, 32'h08, 1'b0);
        pulse(3, 8'hf0);
        apb(1'b0, ADDR_PEND, 32'hf8, 1'b0);
        `CHK(injCount, 0);
        apb(1'b1, ADDR_ENABLE, 32'h08, 1'b0);
        while (injectCall !== 1'b1) cyc(1);
        `CHK(vectorAddr, INT_VECTOR);
        cyc(20);
        `CHK(injCount, 1);
        pulse(2, 8'h00);
        while (injectCall !== 1'b1) cyc(1);
        cyc(4);
        `CHK(injCount, 2);
        apb(1'b1, ADDR_PEND, 32'h08, 1'b0);
        pulse(2, 8'h00);
        cyc(30);
        `CHK(nestBlock, 1'b0);
        `CHK(injCount, 2);
        apb(1'b0, ADDR_PEND, 32'hf0, 1'b0);
        $display("test interrupts done");
        close_out();
    end
endmodule
